// file: hdl/mqae_top.sv
`timescale 1ns/1ps
module mqae_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [mqae_pkg::APB_AW-1:0] PADDR,
  input wire logic [mqae_pkg::APB_DW-1:0] PWDATA,
  output logic [mqae_pkg::APB_DW-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [mqae_pkg::DATA_W-1:0] DIN,
  input wire logic WRITE_EN_N,
  input wire logic [mqae_pkg::QA_W-1:0] WRITE_QUEUE_ADDRESS,
  input wire logic READ_EN_N,
  input wire logic [mqae_pkg::RDA_W-1:0] READ_QUEUE_ADDRESS,
  input wire logic [mqae_pkg::DEV_W-1:0] DEVICE_ID,
  input wire logic DEFAULT_OFFSET_STRAP,
  input wire logic PROGRAM_METHOD_STRAP,
  input wire logic FLAG_BUS_MODE_STRAP,
  input wire logic AE_BUS_STROBE,
  input wire logic AE_TOKEN_IN,
  output logic AE_TOKEN_OUT,
  output logic AE_BUS_SYNC,
  output logic [mqae_pkg::QN-1:0] ALMOST_EMPTY_STATUS_BUS_O,
  output logic ALMOST_EMPTY_STATUS_BUS_OE_N,
  output logic SERIAL_ENABLE_OUT
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // almost-empty is active low: low while the level is at or under the offset
  function automatic logic ae_flag_n(input logic [mqae_pkg::LVL_W-1:0] lvl,
                                     input logic [mqae_pkg::LVL_W-1:0] ofs);
    ae_flag_n = (lvl > ofs);
  endfunction

  // index of a per-queue word register, or -1 when not in the block
  function automatic int reg_index(input logic [mqae_pkg::APB_AW-1:0] addr,
                                   input logic [mqae_pkg::APB_AW-1:0] base);
    logic [mqae_pkg::APB_AW-1:0] diff;
    diff = addr - base;
    if (addr >= base && diff < mqae_pkg::APB_AW'(mqae_pkg::QN * mqae_pkg::REG_STRIDE) && diff[1:0] == 2'b00) begin
      reg_index = int'(diff[mqae_pkg::APB_AW-1:2]);
    end else begin
      reg_index = -1;
    end
  endfunction

  // ----------------------------------------------------------------
  // straps
  // ----------------------------------------------------------------
  mqae_pkg::mqae_cfg_t cfg;
  logic [mqae_pkg::DEV_W-1:0] dev_id;
  logic cfg_valid;

  mqae_strap u_strap (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .default_offset_strap(DEFAULT_OFFSET_STRAP),
    .program_method_strap(PROGRAM_METHOD_STRAP),
    .flag_bus_mode_strap(FLAG_BUS_MODE_STRAP),
    .dev_id_in(DEVICE_ID),
    .cfg(cfg),
    .dev_id(dev_id),
    .cfg_valid(cfg_valid)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic apb_setup, apb_wr, mapped;
  int ofs_idx, lvl_idx;

  always_comb begin
    ofs_idx = reg_index(PADDR, mqae_pkg::ADDR_OFS0);
    lvl_idx = reg_index(PADDR, mqae_pkg::ADDR_LVL0);
    mapped = (PADDR == mqae_pkg::ADDR_CTRL) || (PADDR == mqae_pkg::ADDR_STATUS) ||
             (PADDR == mqae_pkg::ADDR_LAST) || (ofs_idx >= 0) || (lvl_idx >= 0);
  end

  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr = PSEL && PENABLE && PWRITE && mapped;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // ----------------------------------------------------------------
  // programming state and offsets
  // ----------------------------------------------------------------
  // the register port stands in for the serial port; offsets lock once done
  logic done_reg, done_next;
  logic prog_open, prog_wr;
  logic [mqae_pkg::LVL_W-1:0] ofs_reg [mqae_pkg::QN];
  logic [mqae_pkg::LVL_W-1:0] ofs_next [mqae_pkg::QN];
  logic [mqae_pkg::LVL_W-1:0] ofs_eff [mqae_pkg::QN];

  // only serial mode opens the window; the default setup is done at once
  assign prog_open = cfg_valid && !cfg.default_prog && !done_reg;
  assign prog_wr = prog_open && apb_wr;

  always_comb begin
    done_next = done_reg;
    for (int i = 0; i < mqae_pkg::QN; i++) begin
      ofs_next[i] = ofs_reg[i];
    end
    if (cfg_valid && cfg.default_prog) begin
      done_next = 1'b1;
    end else if (prog_wr) begin
      if (PADDR == mqae_pkg::ADDR_CTRL) begin
        done_next = PWDATA[mqae_pkg::CTRL_DONE_BIT];
      end
      if (ofs_idx >= 0) begin
        ofs_next[ofs_idx[mqae_pkg::QA_W-1:0]] = PWDATA[mqae_pkg::LVL_W-1:0];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      done_reg <= 1'b0;
      for (int i = 0; i < mqae_pkg::QN; i++) begin
        ofs_reg[i] <= mqae_pkg::OFS_RESET;
      end
    end else if (CE) begin
      done_reg <= done_next;
      for (int i = 0; i < mqae_pkg::QN; i++) begin
        ofs_reg[i] <= ofs_next[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < mqae_pkg::QN; i++) begin
      if (cfg.default_prog) begin
        ofs_eff[i] = cfg.big_offset ? mqae_pkg::OFS_STRAP_HIGH : mqae_pkg::OFS_STRAP_LOW;
      end else begin
        ofs_eff[i] = ofs_reg[i];
      end
    end
  end

  assign SERIAL_ENABLE_OUT = !done_reg;

  // ----------------------------------------------------------------
  // write capture and queue levels
  // ----------------------------------------------------------------
  // queue storage lives elsewhere; here only the word count per queue and the last written word are kept
  mqae_pkg::mqae_word_t last_reg, last_next;
  logic [mqae_pkg::LVL_W-1:0] lvl_reg [mqae_pkg::QN];
  logic [mqae_pkg::LVL_W-1:0] lvl_next [mqae_pkg::QN];
  logic [mqae_pkg::QN-1:0] flags_n;
  logic wr_go, rd_go;
  logic [mqae_pkg::DEV_W-1:0] rd_dev;
  logic [mqae_pkg::QA_W-1:0] rd_queue;
  logic [mqae_pkg::QN-1:0] wr_hit, rd_hit;

  assign wr_go = !WRITE_EN_N;
  assign rd_go = !READ_EN_N;
  assign rd_dev = READ_QUEUE_ADDRESS[mqae_pkg::RDA_W-1:mqae_pkg::QA_W];
  assign rd_queue = READ_QUEUE_ADDRESS[mqae_pkg::QA_W-1:0];

  // a pop aimed at another device of the chain leaves these levels alone
  always_comb begin
    for (int i = 0; i < mqae_pkg::QN; i++) begin
      wr_hit[i] = wr_go && (WRITE_QUEUE_ADDRESS == mqae_pkg::QA_W'(i));
      rd_hit[i] = rd_go && (rd_queue == mqae_pkg::QA_W'(i)) && (rd_dev == dev_id);
    end
  end

  always_comb begin
    last_next = last_reg;
    if (wr_go) begin
      last_next.data = DIN;
      last_next.queue = WRITE_QUEUE_ADDRESS;
    end
    for (int i = 0; i < mqae_pkg::QN; i++) begin
      lvl_next[i] = lvl_reg[i];
      if (wr_hit[i] && lvl_reg[i] != mqae_pkg::LVL_MAX) begin
        lvl_next[i] = lvl_next[i] + 16'h0001;
      end
      if (rd_hit[i] && lvl_next[i] != '0) begin
        lvl_next[i] = lvl_next[i] - 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      last_reg <= '0;
      for (int i = 0; i < mqae_pkg::QN; i++) begin
        lvl_reg[i] <= '0;
      end
    end else if (CE) begin
      last_reg <= last_next;
      for (int i = 0; i < mqae_pkg::QN; i++) begin
        lvl_reg[i] <= lvl_next[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // almost-empty flags
  // ----------------------------------------------------------------
  // each flag compares the level left by the last edge, so it trails a write by one cycle
  always_comb begin
    for (int i = 0; i < mqae_pkg::QN; i++) begin
      flags_n[i] = ae_flag_n(lvl_reg[i], ofs_eff[i]);
    end
  end

  // ----------------------------------------------------------------
  // almost-empty flag bus
  // ----------------------------------------------------------------
  logic owned;

  mqae_flagbus u_flagbus (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .ready(done_reg),
    .poll_mode(cfg.poll_mode),
    .dev_id(dev_id),
    .strobe(AE_BUS_STROBE),
    .sel_dev(rd_dev),
    .token_in(AE_TOKEN_IN),
    .flags_n(flags_n),
    .bus_o(ALMOST_EMPTY_STATUS_BUS_O),
    .bus_oe_n(ALMOST_EMPTY_STATUS_BUS_OE_N),
    .sync(AE_BUS_SYNC),
    .token_out(AE_TOKEN_OUT),
    .owned(owned)
  );

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  // gathered apart so the read mux stays one level deep
  logic [mqae_pkg::APB_DW-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[mqae_pkg::ST_SEN_BIT] = !done_reg;
    status_word[mqae_pkg::ST_POLL_BIT] = cfg.poll_mode;
    status_word[mqae_pkg::ST_DEFPROG_BIT] = cfg.default_prog;
    status_word[mqae_pkg::ST_BIGOFS_BIT] = cfg.big_offset;
    status_word[mqae_pkg::ST_OWNED_BIT] = owned;
    status_word[mqae_pkg::ST_CFGV_BIT] = cfg_valid;
    status_word[mqae_pkg::ST_AE_LSB +: mqae_pkg::QN] = flags_n;
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // latched in the setup cycle so the access phase needs no wait state
  logic [mqae_pkg::APB_DW-1:0] rdata_reg, rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (apb_setup) begin
      rdata_next = '0;
      if (PADDR == mqae_pkg::ADDR_CTRL) begin
        rdata_next[mqae_pkg::CTRL_DONE_BIT] = done_reg;
      end else if (PADDR == mqae_pkg::ADDR_STATUS) begin
        rdata_next = status_word;
      end else if (PADDR == mqae_pkg::ADDR_LAST) begin
        rdata_next[mqae_pkg::DATA_W-1:0] = last_reg.data;
        rdata_next[mqae_pkg::LAST_Q_LSB +: mqae_pkg::QA_W] = last_reg.queue;
      end else if (ofs_idx >= 0) begin
        rdata_next[mqae_pkg::LVL_W-1:0] = ofs_eff[ofs_idx[mqae_pkg::QA_W-1:0]];
      end else if (lvl_idx >= 0) begin
        rdata_next[mqae_pkg::LVL_W-1:0] = lvl_reg[lvl_idx[mqae_pkg::QA_W-1:0]];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= '0;
    end else if (CE) begin
      rdata_reg <= rdata_next;
    end
  end

  assign PRDATA = rdata_reg;

endmodule // mqae_top

// file: hdl/mqae_pkg.sv
package mqae_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int QN = 4;
  localparam int QA_W = 2;
  localparam int DEV_W = 3;
  localparam int RDA_W = DEV_W + QA_W;
  localparam int LVL_W = 16;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // ----------------------------------------------------------------
  // offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [LVL_W-1:0] OFS_STRAP_LOW = 16'h0008;
  localparam logic [LVL_W-1:0] OFS_STRAP_HIGH = 16'h0080;
  localparam logic [LVL_W-1:0] OFS_RESET = 16'h0008;
  localparam logic [LVL_W-1:0] LVL_MAX = 16'hFFFF;
  localparam logic [DEV_W-1:0] FIRST_DEV = 3'h0;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_LAST = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_OFS0 = 8'h10;
  localparam logic [APB_AW-1:0] ADDR_LVL0 = 8'h20;
  localparam int REG_STRIDE = 4;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_DONE_BIT = 0;
  localparam int ST_SEN_BIT = 0;
  localparam int ST_POLL_BIT = 1;
  localparam int ST_DEFPROG_BIT = 2;
  localparam int ST_BIGOFS_BIT = 3;
  localparam int ST_OWNED_BIT = 4;
  localparam int ST_CFGV_BIT = 5;
  localparam int ST_AE_LSB = 8;
  localparam int LAST_Q_LSB = 20;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic poll_mode;
    logic default_prog;
    logic big_offset;
  } mqae_cfg_t;

  typedef struct packed {
    logic [QA_W-1:0] queue;
    logic [DATA_W-1:0] data;
  } mqae_word_t;

  typedef enum logic [1:0] {
    FB_IDLE = 2'b00,
    FB_POLL = 2'b01,
    FB_DIRECT = 2'b10
  } mqae_fb_state_t;

endpackage

// file: hdl/mqae_strap.sv
`timescale 1ns/1ps
module mqae_strap (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic default_offset_strap,
  input wire logic program_method_strap,
  input wire logic flag_bus_mode_strap,
  input wire logic [mqae_pkg::DEV_W-1:0] dev_id_in,
  output mqae_pkg::mqae_cfg_t cfg,
  output logic [mqae_pkg::DEV_W-1:0] dev_id,
  output logic cfg_valid
);

  // ----------------------------------------------------------------
  // straps caught on the first enabled edge after reset release
  // ----------------------------------------------------------------
  // async reset may only load constants, so the capture is clocked
  mqae_pkg::mqae_cfg_t cfg_reg, cfg_next;
  logic [mqae_pkg::DEV_W-1:0] id_reg, id_next;
  logic valid_reg, valid_next;

  always_comb begin
    cfg_next = cfg_reg;
    id_next = id_reg;
    valid_next = valid_reg;
    if (!valid_reg) begin
      cfg_next.poll_mode = flag_bus_mode_strap;
      cfg_next.default_prog = program_method_strap;
      cfg_next.big_offset = default_offset_strap;
      id_next = dev_id_in;
      valid_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= '0;
      id_reg <= '0;
      valid_reg <= 1'b0;
    end else if (ce) begin
      cfg_reg <= cfg_next;
      id_reg <= id_next;
      valid_reg <= valid_next;
    end
  end

  assign cfg = cfg_reg;
  assign dev_id = id_reg;
  assign cfg_valid = valid_reg;

endmodule // mqae_strap

// file: hdl/mqae_flagbus.sv
`timescale 1ns/1ps
module mqae_flagbus (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ready,
  input wire logic poll_mode,
  input wire logic [mqae_pkg::DEV_W-1:0] dev_id,
  input wire logic strobe,
  input wire logic [mqae_pkg::DEV_W-1:0] sel_dev,
  input wire logic token_in,
  input wire logic [mqae_pkg::QN-1:0] flags_n,
  output logic [mqae_pkg::QN-1:0] bus_o,
  output logic bus_oe_n,
  output logic sync,
  output logic token_out,
  output logic owned
);

  mqae_pkg::mqae_fb_state_t state_reg, state_next;
  logic [mqae_pkg::QN-1:0] bus_reg, bus_next;
  logic started_reg, started_next;
  logic take_poll;

  // ----------------------------------------------------------------
  // ownership of the shared almost-empty bus
  // ----------------------------------------------------------------
  // the first device seeds one token after programming; the ring keeps it alive
  always_comb begin
    state_next = state_reg;
    started_next = started_reg;
    bus_next = flags_n;
    take_poll = token_in | (dev_id == mqae_pkg::FIRST_DEV && !started_reg);
    if (!ready) begin
      state_next = mqae_pkg::FB_IDLE;
    end else if (poll_mode) begin
      started_next = started_reg | (dev_id == mqae_pkg::FIRST_DEV);
      if (take_poll) begin
        state_next = mqae_pkg::FB_POLL;
      end else begin
        state_next = mqae_pkg::FB_IDLE;
      end
    end else if (strobe) begin
      if (sel_dev == dev_id) begin
        state_next = mqae_pkg::FB_DIRECT;
      end else begin
        state_next = mqae_pkg::FB_IDLE;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= mqae_pkg::FB_IDLE;
      started_reg <= 1'b0;
      bus_reg <= '1;
    end else if (ce) begin
      state_reg <= state_next;
      started_reg <= started_next;
      bus_reg <= bus_next;
    end
  end

  assign bus_o = bus_reg;
  assign bus_oe_n = (state_reg == mqae_pkg::FB_IDLE);
  assign sync = (state_reg == mqae_pkg::FB_POLL);
  assign token_out = (state_reg == mqae_pkg::FB_POLL);
  assign owned = (state_reg != mqae_pkg::FB_IDLE);

endmodule // mqae_flagbus

// file: sim/mqae_chain_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far side of the token chain: tie-off, self loop or two neighbours
// ----------------------------------------------------------------
module mqae_chain_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic token_out,
  output logic token_in
);
  logic [1:0] hop_reg;
  logic [1:0] hop_next;
  // each neighbour holds the bus one cycle, then passes the token on
  always_comb begin
    hop_next = {hop_reg[0], token_out};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hop_reg <= 2'h0;
    end else begin
      hop_reg <= hop_next;
    end
  end
  always_comb begin
    case (mode)
      2'h1: token_in = token_out;
      2'h2: token_in = hop_reg[1];
      default: token_in = 1'b0;
    endcase
  end
endmodule // mqae_chain_model

// file: sim/mqae_top_props.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// almost-empty bus checker
// ----------------------------------------------------------------
module mqae_top_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [mqae_pkg::RDA_W-1:0] READ_QUEUE_ADDRESS,
  input wire logic [mqae_pkg::DEV_W-1:0] DEVICE_ID,
  input wire logic FLAG_BUS_MODE_STRAP,
  input wire logic AE_BUS_STROBE,
  input wire logic AE_TOKEN_IN,
  input wire logic AE_TOKEN_OUT,
  input wire logic AE_BUS_SYNC,
  input wire logic ALMOST_EMPTY_STATUS_BUS_OE_N,
  input wire logic SERIAL_ENABLE_OUT
);
  logic go;
  logic hit;
  logic fm;
  logic oe_n;
  // straps are held stable by the board, so the pin stands in for the caught mode
  assign fm = FLAG_BUS_MODE_STRAP;
  assign oe_n = ALMOST_EMPTY_STATUS_BUS_OE_N;
  assign go = CE && !SERIAL_ENABLE_OUT;
  assign hit = READ_QUEUE_ADDRESS[4:2] == DEVICE_ID;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_sync_token: assert property (AE_BUS_SYNC == AE_TOKEN_OUT)
    else $error("sync differs from token out");
  a_sync_drives: assert property (AE_BUS_SYNC |-> !oe_n)
    else $error("sync high while bus undriven");
  a_token_take: assert property (fm && AE_TOKEN_IN && go |=> AE_BUS_SYNC && !oe_n)
    else $error("token not taken");
  a_sync_single: assert property (fm && AE_BUS_SYNC && !AE_TOKEN_IN && CE |=> !AE_BUS_SYNC)
    else $error("sync held without token");
  a_direct_take: assert property (!fm && AE_BUS_STROBE && hit && go |=> !oe_n)
    else $error("selected device not driving");
  a_direct_drop: assert property (!fm && AE_BUS_STROBE && !hit && go |=> oe_n)
    else $error("unselected device drives");
  a_direct_hold: assert property (!fm && !AE_BUS_STROBE && go |=> $stable(oe_n))
    else $error("ownership moved without strobe");
  a_direct_quiet: assert property (!fm |-> !AE_BUS_SYNC)
    else $error("sync in direct mode");
  a_idle_prog: assert property (SERIAL_ENABLE_OUT |-> oe_n && !AE_BUS_SYNC)
    else $error("bus active before programming");
endmodule // mqae_top_props

bind mqae_top mqae_top_props i_props (.CLK(CLK), .RST(RST), .CE(CE), .READ_QUEUE_ADDRESS(READ_QUEUE_ADDRESS),
  .DEVICE_ID(DEVICE_ID), .FLAG_BUS_MODE_STRAP(FLAG_BUS_MODE_STRAP), .AE_BUS_STROBE(AE_BUS_STROBE),
  .AE_TOKEN_IN(AE_TOKEN_IN), .AE_TOKEN_OUT(AE_TOKEN_OUT), .AE_BUS_SYNC(AE_BUS_SYNC),
  .ALMOST_EMPTY_STATUS_BUS_OE_N(ALMOST_EMPTY_STATUS_BUS_OE_N), .SERIAL_ENABLE_OUT(SERIAL_ENABLE_OUT));

// file: sim/mqae_top_bench.sv
`timescale 1ns/1ps
module mqae_top_bench;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
  } mqae_row_t;
  logic clk, prdy, perr, tin, tout, sync, oe_n, sen, err;
  logic rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, wen_n = 1'b1, ren_n = 1'b1;
  logic df = 1'b0, pm = 1'b1, fm = 1'b0;
  logic ce = 1'b1;
  // strobe only pulses in direct mode once programming is over
  logic stb = 1'b0;
  logic [7:0] padr = 8'h0;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, rd;
  logic [17:0] din = 18'h0;
  logic [1:0] wq = 2'h0, mode = 2'h0;
  logic [4:0] rqa = 5'h0;
  logic [2:0] dev = 3'h0;
  logic [3:0] bus, cnt;
  int fail_count, tests_run;
  mqae_row_t rows [7] = '{'{8'h10, 32'h8}, '{8'h14, 32'h8}, '{8'h18, 32'h8}, '{8'h1C, 32'h8},
    '{8'h20, 32'h0}, '{8'h04, 32'h24}, '{8'h00, 32'h1}};

  mqae_top i_dut (.CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .DIN(din), .WRITE_EN_N(wen_n),
    .WRITE_QUEUE_ADDRESS(wq), .READ_EN_N(ren_n), .READ_QUEUE_ADDRESS(rqa), .DEVICE_ID(dev),
    .DEFAULT_OFFSET_STRAP(df), .PROGRAM_METHOD_STRAP(pm), .FLAG_BUS_MODE_STRAP(fm), .AE_BUS_STROBE(stb),
    .AE_TOKEN_IN(tin), .AE_TOKEN_OUT(tout), .AE_BUS_SYNC(sync), .ALMOST_EMPTY_STATUS_BUS_O(bus),
    .ALMOST_EMPTY_STATUS_BUS_OE_N(oe_n), .SERIAL_ENABLE_OUT(sen));
  mqae_chain_model i_far (.clk(clk), .rst(rst), .mode(mode), .token_out(tout), .token_in(tin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 64);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 64) chk(32'h0, 32'h1, "apb hang");
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "register read");
  endtask

  // back-to-back writes of consecutive words
  task automatic burst(input logic [1:0] q, input int n, input logic [17:0] base);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      wen_n <= 1'b0;
      wq <= q;
      din <= base + 18'(i);
      @(posedge clk);
    end
    wen_n <= 1'b1;
    din <= 18'h0;
  endtask

  // straps change only while reset is held, then stay put
  task automatic do_reset(input logic d, input logic p, input logic f, input logic [2:0] id, input logic [1:0] m);
    @(posedge clk);
    rst <= 1'b1;
    df <= d;
    pm <= p;
    fm <= f;
    dev <= id;
    mode <= m;
    repeat (12) @(posedge clk);
    chk({sen, oe_n, sync}, 3'b110, "reset idle");
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic sel(input logic [4:0] a);
    @(posedge clk);
    stb <= 1'b1;
    rqa <= a;
    @(posedge clk);
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    do_reset(1'b0, 1'b1, 1'b0, 3'h2, 2'h0);
    foreach (rows[i]) begin
      rdchk(rows[i].a, rows[i].d);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1, "unmapped");
    apb(1'b1, 8'h10, 32'h5);
    rdchk(8'h10, 32'h8);
    burst(2'h1, 1, 18'h3FFFF);
    rdchk(8'h08, 32'h0013FFFF);
    rdchk(8'h24, 32'h1);
    burst(2'h0, 9, 18'h100);
    rdchk(8'h20, 32'h9);
    // clock enable low: both writes must be lost
    ce <= 1'b0;
    burst(2'h2, 2, 18'h5);
    ce <= 1'b1;
    rdchk(8'h28, 32'h0);
    sel(5'h08);
    chk(oe_n, 1'b0, "own");
    chk(bus, 4'h1, "flags");
    @(posedge clk);
    ren_n <= 1'b0;
    @(posedge clk);
    ren_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(bus, 4'h0, "offset edge");
    sel(5'h14);
    chk(oe_n, 1'b1, "release");
    $display("direct test done");
    do_reset(1'b1, 1'b1, 1'b1, 3'h0, 2'h1);
    rdchk(8'h18, 32'h80);
    repeat (4) begin
      @(posedge clk);
      chk({sync, tout, oe_n}, 3'b110, "loop");
    end
    $display("loop test done");
    do_reset(1'b0, 1'b0, 1'b1, 3'h0, 2'h2);
    chk({sen, oe_n}, 2'b11, "serial wait");
    apb(1'b1, 8'h10, 32'h5);
    rdchk(8'h10, 32'h5);
    apb(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge clk);
    chk(sen, 1'b0, "programmed");
    cnt = 4'h0;
    repeat (9) begin
      @(posedge clk);
      cnt = cnt + {3'h0, sync};
    end
    chk(cnt, 4'h3, "ring");
    $display("ring test done");
    end_sim;
  end

  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    end_sim;
  end
endmodule // mqae_top_bench
